//--- hw/pwd_watchdog.sv
// pwd_watchdog: counter array with watchdog compare module and apb registers
// assumes pclk is the system clock; inputs synchronous to pclk
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pwd_watchdog (
   // apb
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // system
   input  wire pwd_pkg::pwd_sys_s sys_in,
   output logic                   wd_reset_req
);
   import pwd_pkg::*;

   // counter array state
   logic [7:0]  array_count_low_r;
   logic [7:0]  array_count_low_nxt;
   logic [7:0]  array_count_high_r;
   logic [7:0]  array_count_high_nxt;

   // watchdog compare module
   logic [7:0]  wd_offset_value_r;
   logic [7:0]  wd_offset_value_nxt;
   logic [7:0]  wd_compare_high_r;
   logic [7:0]  wd_compare_high_nxt;

   // control and mode
   logic        run_r;
   logic        run_nxt;
   logic        match2_r;
   logic        match2_nxt;
   pwd_mode_s   mode_r;
   pwd_mode_s   mode_nxt;

   // prescalers and edge detect
   logic [3:0]  div12_r;
   logic [3:0]  div12_nxt;
   logic [1:0]  div4_r;
   logic [1:0]  div4_nxt;
   logic [2:0]  div8_r;
   logic [2:0]  div8_nxt;
   logic        ext_prev_r;

   // outputs
   logic        wd_reset_req_nxt;
   logic [31:0] prdata_nxt;

   // address hits
   wire hit_ctrl   = paddr == ADDR_CONTROL;
   wire hit_mode   = paddr == ADDR_MODE;
   wire hit_low    = paddr == ADDR_CNT_LOW;
   wire hit_high   = paddr == ADDR_CNT_HIGH;
   wire hit_offset = paddr == ADDR_OFFSET;
   wire hit_cmp    = paddr == ADDR_CMP_HIGH;
   wire mapped     = hit_ctrl | hit_mode | hit_low
                   | hit_high | hit_offset | hit_cmp;

   // write strobes land on the access edge
   wire access     = psel & penable;
   wire wr_en      = access & pwrite;
   wire rd_setup   = psel & ~penable & ~pwrite;
   wire wr_ctrl    = wr_en & hit_ctrl;
   wire wr_mode    = wr_en & hit_mode;
   wire wr_low     = wr_en & hit_low;
   wire wr_high    = wr_en & hit_high;
   wire wr_offset  = wr_en & hit_offset;
   wire wr_cmp     = wr_en & hit_cmp;

   wire wd_active = mode_r.watchdog_enable | mode_r.watchdog_lock; // [R11]

   // counter clock sources
   wire ext_rise  = sys_in.ext_clock & ~ext_prev_r;
   wire tick_12   = div12_r == DIV12_LAST; // [R16]
   wire tick_4    = div4_r == DIV4_LAST;
   wire tick_8    = div8_r == DIV8_LAST;
   logic src_tick;
   always_comb begin
      unique case (mode_r.array_clock_select) // [R8]
         SEL_DIV12: src_tick = tick_12;
         SEL_DIV4:  src_tick = tick_4;
         SEL_TIMER: src_tick = sys_in.timer_overflow;
         SEL_EXTE:  src_tick = ext_rise;
         SEL_SYS:   src_tick = 1'b1;
         SEL_EXT8:  src_tick = tick_8;
         default:   src_tick = 1'b0;
      endcase
   end

   wire suspended = mode_r.idle_count_stop & sys_in.processor_idle; // [R9]
   wire cnt_tick  = src_tick & run_r & ~suspended;
   wire wd_tick   = src_tick & ~suspended;
   wire low_ovf   = wd_tick && array_count_low_r == 8'hff; // [R17]
   // watchdog keeps the count moving even if the run bit is clear
   wire count_en  = cnt_tick | (wd_active & wd_tick);
   wire match     = array_count_high_r == wd_compare_high_r; // [R1]
   wire timeout   = wd_active & count_en & low_ovf & match; // [R4]
   wire forced    = wd_active & wr_ctrl & pwdata[BIT_MATCH2]; // [R5]

   // mode register: lock sticks, selects frozen while enabled
   always_comb begin
      mode_nxt = mode_r;
      if (wr_mode) begin
         mode_nxt.watchdog_enable = pwdata[BIT_ENABLE]; // [R13]
         mode_nxt.watchdog_lock = mode_r.watchdog_lock
                                | pwdata[BIT_LOCK]; // [R12]
         if (!wd_active) begin
            mode_nxt.array_clock_select = pwdata[SEL_LSB +: 3]; // [R10]
            mode_nxt.idle_count_stop = pwdata[BIT_IDLESTOP]; // [R10]
         end
      end
   end

   // offset register changes only on software writes, never on the feed
   always_comb begin
      wd_offset_value_nxt = wr_offset ? pwdata[7:0] : wd_offset_value_r;
   end

   assign wd_reset_req_nxt = timeout | forced; // [R18]

   // prescaler next values
   assign div12_nxt = tick_12 ? 4'h0 : div12_r + 4'h1;
   assign div4_nxt  = div4_r + 2'h1;
   assign div8_nxt  = ext_rise ? div8_r + 3'h1 : div8_r;

   // low byte: software write wins over the count
   always_comb begin
      array_count_low_nxt = array_count_low_r;
      if (wr_low) begin
         array_count_low_nxt = pwdata[7:0];
      end else if (count_en) begin
         array_count_low_nxt = array_count_low_r + 8'h01; // [R17]
      end
   end

   // high byte takes the carry of the low byte
   always_comb begin
      array_count_high_nxt = array_count_high_r;
      if (wr_high) begin
         array_count_high_nxt = pwdata[7:0];
      end else if (count_en && low_ovf) begin
         array_count_high_nxt = array_count_high_r + 8'h01; // [R17]
      end
   end

   // feed: compare high becomes current high byte plus offset
   always_comb begin
      wd_compare_high_nxt = wd_compare_high_r;
      if (wr_cmp) begin
         wd_compare_high_nxt = array_count_high_r
                             + wd_offset_value_r; // [R7] [R2] [R3]
      end
   end

   // run bit follows control writes
   always_comb begin
      run_nxt = run_r;
      if (wr_ctrl) begin
         run_nxt = pwdata[BIT_RUN];
      end
   end

   // module2 flag: hardware set wins over software clear
   always_comb begin
      match2_nxt = match2_r;
      if (!wd_active && count_en && low_ovf && match) begin
         match2_nxt = 1'b1;
      end else if (wr_ctrl && !wd_active) begin
         match2_nxt = pwdata[BIT_MATCH2];
      end
   end

   // mode register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= '{idle_count_stop: 1'b0, array_clock_select: SEL_RST,
                     watchdog_lock: 1'b0, watchdog_enable: 1'b1}; // [R14]
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // offset register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_offset_value_r <= RST_OFFSET; // [R15]
      end else begin
         wd_offset_value_r <= wd_offset_value_nxt;
      end
   end

   // registered reset request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_reset_req <= 1'b0;
      end else begin
         wd_reset_req <= wd_reset_req_nxt;
      end
   end

   // previous level of the external clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= sys_in.ext_clock;
      end
   end

   // divide by 12, free running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div12_r <= 4'h0;
      end else begin
         div12_r <= div12_nxt;
      end
   end

   // divide by 4, free running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div4_r <= 2'h0;
      end else begin
         div4_r <= div4_nxt;
      end
   end

   // external edges divided by 8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div8_r <= 3'h0;
      end else begin
         div8_r <= div8_nxt;
      end
   end

   // count low byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         array_count_low_r <= RST_LOW; // [R15]
      end else begin
         array_count_low_r <= array_count_low_nxt;
      end
   end

   // count high byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         array_count_high_r <= RST_HIGH;
      end else begin
         array_count_high_r <= array_count_high_nxt;
      end
   end

   // compare high byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_compare_high_r <= RST_CMP;
      end else begin
         wd_compare_high_r <= wd_compare_high_nxt;
      end
   end

   // run bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
      end else begin
         run_r <= run_nxt;
      end
   end

   // module2 flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match2_r <= 1'b0;
      end else begin
         match2_r <= match2_nxt;
      end
   end

   // read mux
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      unique case (paddr)
         ADDR_CONTROL: begin
            rd_byte = 8'h00;
            rd_byte[BIT_RUN]    = run_r;
            rd_byte[BIT_MATCH2] = match2_r;
         end
         ADDR_MODE: begin
            rd_byte = 8'h00;
            rd_byte[BIT_IDLESTOP]     = mode_r.idle_count_stop;
            rd_byte[BIT_ENABLE]       = mode_r.watchdog_enable;
            rd_byte[BIT_LOCK]         = mode_r.watchdog_lock;
            rd_byte[SEL_LSB +: 3]     = mode_r.array_clock_select;
         end
         ADDR_CNT_LOW:  rd_byte = array_count_low_r;
         ADDR_CNT_HIGH: rd_byte = array_count_high_r;
         ADDR_OFFSET:   rd_byte = wd_offset_value_r;
         ADDR_CMP_HIGH: rd_byte = wd_compare_high_r;
         default:       rd_byte = 8'h00;
      endcase
   end

   // read data captured in the setup cycle, held until the next read
   assign prdata_nxt = rd_setup ? {24'h00_0000, rd_byte} : prdata;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= prdata_nxt;
      end
   end

   // apb response: no wait states

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
endmodule // pwd_watchdog

//--- hw/pwd_pkg.sv
// pwd_pkg: constants, types and register map of the counter-array watchdog
// assumes an apb slave at pclk, 32-bit data, one register per aligned word
//
// Contract
// [R1] compare high register compared with the high byte of the 16-bit count
// [R2] offset counts low-byte overflows; first overflow takes up to 256 clocks
// [R3] interval is 256 times offset plus 256 minus low byte at feed
// [R4] reset when low byte overflows while high byte equals compare high
// [R5] writing 1 to module2 match flag forces reset while watchdog enabled
// [R6] software disables, selects clock, loads offset, idle, enables, then feeds
// [R7] any write to compare high restarts the interval as the feed
// [R8] 3-bit clock select chooses the counter clock source
// [R9] idle stop set suspends counter and watchdog during processor idle
// [R10] clock select and idle stop writes ignored while watchdog enabled
// [R11] watchdog enabled when enable bit or lock bit is set
// [R12] lock holds watchdog enabled until next system reset
// [R13] with lock clear, clearing enable disables the watchdog
// [R14] enable bit comes up set after any reset
// [R15] defaults: clock system_clock/12, low byte 0x00, offset 0x00
// [R16] defaults give 256 counter clocks, 3072 system clocks
// [R17] 16-bit up counter, low byte carries into high byte
// [R18] reset is a synchronous request; system reset restores all defaults
package pwd_pkg;
   localparam logic [7:0] ADDR_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_MODE      = 8'h04;
   localparam logic [7:0] ADDR_CNT_LOW   = 8'h08;
   localparam logic [7:0] ADDR_CNT_HIGH  = 8'h0c;
   localparam logic [7:0] ADDR_OFFSET    = 8'h10;
   localparam logic [7:0] ADDR_CMP_HIGH  = 8'h14;

   localparam int BIT_MATCH2   = 2;
   localparam int BIT_RUN      = 6;
   localparam int BIT_IDLESTOP = 7;
   localparam int BIT_LOCK     = 5;
   localparam int BIT_ENABLE   = 6;
   localparam int SEL_LSB      = 1;

   localparam logic [2:0] SEL_DIV12 = 3'h0;
   localparam logic [2:0] SEL_DIV4  = 3'h1;
   localparam logic [2:0] SEL_TIMER = 3'h2;
   localparam logic [2:0] SEL_EXTE  = 3'h3;
   localparam logic [2:0] SEL_SYS   = 3'h4;
   localparam logic [2:0] SEL_EXT8  = 3'h5;
   localparam logic [2:0] SEL_RST   = SEL_DIV12;
   localparam logic [7:0] RST_LOW    = 8'h00;
   localparam logic [7:0] RST_HIGH   = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_CMP    = 8'h00;
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [1:0] DIV4_LAST  = 2'h3;
   localparam logic [2:0] DIV8_LAST  = 3'h7;
   localparam int DEFAULT_TIMEOUT_SYS = 3072;

   typedef struct packed {
      logic        idle_count_stop;
      logic [2:0]  array_clock_select;
      logic        watchdog_lock;
      logic        watchdog_enable;
   } pwd_mode_s;

   typedef struct packed {
      logic       processor_idle;
      logic       timer_overflow;
      logic       ext_clock;
   } pwd_sys_s;
endpackage

//--- test/pwd_watchdog_checker.sv
// pwd_watchdog_checker: port assertions for the counter-array watchdog
// assumes one pclk domain; mode state is mirrored from apb writes
`timescale 1ns/1ps
module pwd_watchdog_checker
   import pwd_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire pwd_pkg::pwd_sys_s sys_in,
   input wire logic              wd_reset_req
);
   logic       en_r, lk_r, idl_r;
   logic [2:0] sel_r;
   logic [7:0] off_r;
   wire acc = psel & penable & pready;
   wire rd_mode = acc & !pwrite & (paddr == ADDR_MODE);
   wire wr_mode = acc & pwrite & (paddr == ADDR_MODE);
   wire wr_off = acc & pwrite & (paddr == ADDR_OFFSET);
   wire frc = acc & pwrite & (paddr == ADDR_CONTROL) & pwdata[BIT_MATCH2];
   wire wd_on = en_r | lk_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r  <= 1'b1;
         lk_r  <= 1'b0;
         idl_r <= 1'b0;
         sel_r <= SEL_RST;
      end else if (wr_mode) begin
         en_r <= pwdata[BIT_ENABLE];
         lk_r <= lk_r | pwdata[BIT_LOCK];
         if (!wd_on) begin
            sel_r <= pwdata[SEL_LSB+:3];
            idl_r <= pwdata[BIT_IDLESTOP];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) off_r <= RST_OFFSET;
      else if (wr_off) off_r <= pwdata[7:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   force_reset_a: assert property (frc && wd_on |=> wd_reset_req)
      else $error("forced reset missing");
   quiet_off_a: assert property (!wd_on && $past(!wd_on, 2) |-> !wd_reset_req)
      else $error("reset request while disabled");
   lock_read_a: assert property (rd_mode |-> prdata[BIT_LOCK] == lk_r)
      else $error("lock bit wrong");
   enable_read_a: assert property (rd_mode && !lk_r |-> prdata[BIT_ENABLE] == en_r)
      else $error("enable bit wrong");
   select_hold_a: assert property (rd_mode |-> prdata[SEL_LSB+:3] == sel_r)
      else $error("clock select wrong");
   idle_hold_a: assert property (rd_mode |-> prdata[BIT_IDLESTOP] == idl_r)
      else $error("idle stop wrong");
   offset_read_a: assert property (acc && !pwrite && paddr == ADDR_OFFSET
      |-> prdata[7:0] == off_r)
      else $error("offset wrong");
   lock_stays_a: assert property (lk_r && frc |=> wd_reset_req)
      else $error("locked watchdog not enabled");
endmodule // pwd_watchdog_checker
bind pwd_watchdog pwd_watchdog_checker chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sys_in(sys_in), .wd_reset_req(wd_reset_req));

//--- test/test_pwd_watchdog.sv
// test_pwd_watchdog: random and corner tests of the watchdog over apb
// assumes pclk 25 MHz and the bound port checker
`timescale 1ns/1ps
module test_pwd_watchdog;
   import pwd_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        idle_on = 0, pready, pslverr, wd_reset_req, rerr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'd99;
   pwd_sys_s    sys_in = '0;
   int          error_cnt = 0, comparisons = 0, n;
   always #20 pclk = ~pclk;
   pwd_watchdog uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_in(sys_in),
      .wd_reset_req(wd_reset_req));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] mw(logic e, logic i, logic [2:0] s);
      return {24'h0, i, e, 2'b00, s, 1'b0};
   endfunction
   always @(posedge pclk) sys_in <= {idle_on, xs() % 2 == 0, seed[3]};
   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rst();
      presetn <= 0;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
   endtask
   task automatic wait_req(output int c);
      c = 0;
      while (wd_reset_req !== 1'b1) begin
         @(posedge pclk);
         c++;
      end
   endtask
   task automatic run(input logic [7:0] off, input logic idl);
      int e;
      apb(1, ADDR_MODE, 32'h0);
      apb(1, ADDR_MODE, mw(0, idl, SEL_SYS));
      apb(1, ADDR_OFFSET, {24'h0, off});
      apb(1, ADDR_MODE, mw(1, idl, SEL_SYS));
      do apb(0, ADDR_CNT_LOW, 32'h0); while (rdat[7:0] > 8'hf0);
      apb(1, ADDR_CMP_HIGH, xs());
      e = 256 * off + 256 - (rdat[7:0] + 4) + (idl ? 100 : 0);
      idle_on <= idl;
      repeat (100) @(posedge pclk);
      idle_on <= 0;
      wait_req(n);
      chk("interval", 1, n + 100 inside {[e - 4:e + 4]});
      rst();
   endtask
   task automatic final_report();
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      final_report();
   end
   initial begin
      rst();
      apb(0, ADDR_MODE, 32'h0);
      chk("mode", 32'h40, rdat);
      wait_req(n);
      chk("default", 1, n + 3 inside {[3070:3078]});
      rst();
      run(8'h00, 0);
      run(8'(xs() % 3 + 1), 1);
      apb(1, ADDR_MODE, 32'h20);
      apb(1, ADDR_CONTROL, 32'h4);
      chk("force", 1, wd_reset_req);
      rst();
      apb(0, ADDR_MODE, 32'h0);
      chk("mode", 32'h40, rdat);
      for (int s = 0; s < 6; s++) begin
         apb(1, ADDR_MODE, mw(0, s[0], 3'(s)));
         apb(0, ADDR_MODE, 32'h0);
         chk("sel", mw(0, s[0], 3'(s)), rdat);
      end
      apb(1, ADDR_MODE, mw(1, 0, SEL_SYS));
      apb(1, ADDR_MODE, mw(1, 1, SEL_DIV4));
      apb(0, ADDR_MODE, 32'h0);
      chk("locked sel", mw(1, 0, SEL_SYS), rdat);
      apb(1, ADDR_MODE, 32'h0);
      apb(1, ADDR_CONTROL, 32'h4);
      repeat (4000) @(posedge pclk);
      chk("off", 0, wd_reset_req);
      apb(0, 8'h3c, 32'h0);
      chk("unmapped", 1, rerr);
      final_report();
   end
endmodule // test_pwd_watchdog
